// ===== logic/tcp_pkg.sv
// Package: register map, field layout, reset values and carrier types of the timer
`default_nettype none
package tcp_pkg;
  localparam int NCH = 5;
  localparam int CW = 16;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int PRE_W = 6;

  // Register indexes; the byte address of a register is four times its index
  localparam logic [31:0] CH0_COUNTER_CONTROL_IDX = 32'hffff8260;
  localparam logic [31:0] CH0_OPERATING_MODE_IDX = 32'hffff8261;
  localparam logic [31:0] CH0_PIN_IO_CONTROL_HIGH_IDX = 32'hffff8262;
  localparam logic [31:0] CH0_COMPARE_A_IDX = 32'hffff8268;
  localparam logic [AW-1:0] CH_BASE = CH0_COUNTER_CONTROL_IDX[AW-1:0];
  localparam logic [AW-1:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] FLD_CTRL = CH0_COUNTER_CONTROL_IDX[3:0];
  localparam logic [3:0] FLD_MODE = CH0_OPERATING_MODE_IDX[3:0];
  localparam logic [3:0] FLD_IOH = CH0_PIN_IO_CONTROL_HIGH_IDX[3:0];
  localparam logic [3:0] FLD_IOL = 4'h3;
  localparam logic [3:0] FLD_STAT = 4'h5;
  localparam logic [3:0] FLD_CNT = 4'h6;
  localparam logic [3:0] FLD_CMP_A = CH0_COMPARE_A_IDX[3:0];
  localparam logic [3:0] FLD_CMP_B = 4'h9;
  localparam logic [3:0] FLD_CMP_C = 4'ha;
  localparam logic [3:0] FLD_CMP_D = 4'hb;
  localparam logic [AW-1:0] START_IDX = 8'hb0;

  // Start register bit of each channel, and channels that own compare C and D
  localparam int START_BIT [NCH] = '{0, 1, 2, 6, 7};
  localparam logic [7:0] START_MASK = 8'hc7;
  localparam logic [NCH-1:0] CH_HAS_CD = 5'b11001;

  // Counter control fields and codes
  localparam int CKS_LSB = 0;
  localparam int CKS_W = 3;
  localparam int CLR_LSB = 5;
  localparam int CLR_W = 3;
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  // Mode field and codes
  localparam int MD_LSB = 0;
  localparam int MD_W = 4;
  localparam logic [3:0] MD_PWM1 = 4'h2;
  // Pin control nibble
  localparam int IO_INIT_BIT = 2;
  localparam int IO_CAP_BIT = 3;
  localparam logic [1:0] IO_LOW = 2'h1;
  localparam logic [1:0] IO_HIGH = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  // Status fields
  localparam int STAT_OVF_BIT = 4;
  localparam int STAT_PIN_LSB = 8;

  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [CW-1:0] RST_CMP = 16'hffff;
  localparam logic [CW-1:0] RST_CNT = 16'h0000;
  localparam logic [7:0] RST_START = 8'h00;

  // Timing: one count of the undivided clock is one period of clk_i
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REF_PCLK_KHZ = 20000;
  localparam int REF_COUNT_PS = 50000;
  localparam int COUNT_PERIOD_PS = CLK_PERIOD_PS;
  localparam int CYC_PER_COUNT = (COUNT_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic rd;
    logic wr;
    logic [DW-1:0] wdata;
    logic [3:0] be;
  } tcp_req_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] io_h;
    logic [7:0] io_l;
    logic [CW-1:0] cmp_a;
    logic [CW-1:0] cmp_b;
    logic [CW-1:0] cmp_c;
    logic [CW-1:0] cmp_d;
  } tcp_chcfg_s;

  localparam tcp_chcfg_s CFG_RST = '{ctrl: RST_REG8, mode: RST_REG8, io_h: RST_REG8,
    io_l: RST_REG8, cmp_a: RST_CMP, cmp_b: RST_CMP, cmp_c: RST_CMP, cmp_d: RST_CMP};

  function automatic logic [15:0] tcp_merge(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be);
    tcp_merge = old;
    if (be[0]) begin
      tcp_merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      tcp_merge[15:8] = wd[15:8];
    end
  endfunction
endpackage
`default_nettype wire

// ===== logic/tcp_avalon_slave.sv
// Avalon-MM slave front end: one request taken per access, registered answer
`default_nettype none
module tcp_avalon_slave
  import tcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output tcp_req_s req_o,
  input wire logic [DW-1:0] rdata_i
);
  logic wait_r;
  logic [DW-1:0] rdata_r;
  logic take;

  // A request is taken once; the following cycle releases it with waitrequest low
  assign take = ce_i & wait_r & (avs_read_i | avs_write_i);
  assign req_o = '{addr: avs_address_i, rd: take & avs_read_i, wr: take & avs_write_i,
                   wdata: avs_writedata_i, be: avs_byteenable_i};
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
    end else if (ce_i) begin
      wait_r <= ~take;
      if (take & avs_read_i) begin
        rdata_r <= rdata_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/tcp_counter.sv
// Channel counter: 16-bit up-count, compare matches, clearing and software load
`default_nettype none
module tcp_counter
  import tcp_pkg::*;
#(
  parameter bit HAS_CD = 1'b1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire tcp_chcfg_s cfg_i,
  input wire logic load_i,
  input wire logic [CW-1:0] load_val_i,
  output logic [CW-1:0] cnt_o,
  output logic [3:0] match_o,
  output logic ovf_o
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [3:0] eq;
  logic [2:0] clr_sel;
  logic clr_hit;

  assign clr_sel = cfg_i.ctrl[CLR_LSB +: CLR_W];
  assign eq[0] = cnt_r == cfg_i.cmp_a;
  assign eq[1] = cnt_r == cfg_i.cmp_b;
  assign eq[2] = HAS_CD && (cnt_r == cfg_i.cmp_c);
  assign eq[3] = HAS_CD && (cnt_r == cfg_i.cmp_d);
  // Match in the counting cycle whose value equals the compare value
  assign match_o = (tick_i && !load_i) ? eq : 4'h0;
  assign clr_hit = (clr_sel == CLR_A && match_o[0]) ||
                   (clr_sel == CLR_B && match_o[1]) ||
                   (clr_sel == CLR_C && match_o[2]) ||
                   (clr_sel == CLR_D && match_o[3]);
  assign ovf_o = tick_i && !load_i && !clr_hit && (&cnt_r);
  assign cnt_nxt = load_i ? load_val_i : (clr_hit ? RST_CNT : cnt_r + 16'h0001);
  assign cnt_o = cnt_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= RST_CNT;
    end else if (ce_i && (load_i || tick_i)) begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== logic/tcp_timer.sv
// Top level: five-channel compare timer with toggle output and PWM mode 1
//
// Behaviour
// - Clear-on-compare-A control setting clears channel 0 counter at each compare A match.
// - That control setting counts on the undivided clock, one step per cycle.
// - Pin control 03 hex: pin A starts low, inverts at every compare A match.
// - Mode value c0 hex gives normal, non-PWM counting.
// - Clearing plus toggling gives a continuous 50% duty square wave.
// - Each programmed count equals one peripheral clock period.
// - Toggled pulse width programmable from one count up to 65536 counts.
// - A counter stays halted until its start bit is set; setting it counts. Here clock select values 4 to 7 give no count even with the bit set.
// - In PWM mode 1 each channel has its own period.
// - Channels 0, 3, 4 give two PWM outputs; channels 1, 2 give one.
// - Compare A pairs with B, C with D; each pair drives one PWM output.
// - Channels 0 to 4 together give up to eight PWM phases.
// - PWM duty settable from 0% to 100% in steps of one count.
// - Each channel selects its own clearing source and counting clock.
// - Four-phase use drives channel 1 A, channel 2 A, channel 3 A and C.
// - Pin control 02 hex: starts low, low at period match, high at duty match.
// - Mode value c2 hex selects PWM mode 1.
//
// Added by the designer: the Avalon-MM interface to the registers.
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [4*NCH-1:0] pin_o,
  output logic [4*NCH-1:0] pin_oe_o
);
  tcp_req_s req;
  logic [DW-1:0] rdata;
  logic [DW-1:0] ch_rdata [NCH];
  logic [NCH-1:0] ch_hit;
  logic [PRE_W-1:0] pre_r;
  logic [3:0] div_tick;
  logic [7:0] start_r;
  logic start_hit;

  tcp_avalon_slave u_bus (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .req_o(req),
    .rdata_i(rdata)
  );

  // Shared prescaler for the divided counting clocks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_r <= '0;
    end else if (ce_i) begin
      pre_r <= pre_r + PRE_W'(1);
    end
  end

  assign div_tick[0] = 1'b1;
  assign div_tick[1] = &pre_r[1:0];
  assign div_tick[2] = &pre_r[3:0];
  assign div_tick[3] = &pre_r[5:0];

  // Start register, one bit per channel
  assign start_hit = req.addr == START_IDX;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_r <= RST_START;
    end else if (ce_i && req.wr && start_hit && req.be[0]) begin
      start_r <= req.wdata[7:0] & START_MASK;
    end
  end

  // Channels 0 to 4; channels 1 and 2 lack compare C and D and pins C and D
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    localparam logic [AW-1:0] ADR = AW'(int'(CH_BASE) + int'(CH_STRIDE) * n);
    localparam bit CD = CH_HAS_CD[n];
    tcp_chcfg_s cfg_r;
    tcp_chcfg_s cfg_nxt;
    logic [7:0] stat_r;
    logic [7:0] stat_nxt;
    logic [3:0] pin_r;
    logic [3:0] pin_nxt;
    logic [3:0] oe_r;
    logic [3:0] oe_nxt;
    logic [3:0] fld;
    logic wr;
    logic [15:0] wd16;
    logic [1:0] be2;
    logic [CW-1:0] cnt;
    logic [3:0] match;
    logic ovf;
    logic run;
    logic tick;
    logic pwm;
    logic [2:0] cks;
    logic cnt_load;
    logic io_wr_h;
    logic io_wr_l;
    logic stat_wr;
    logic [3:0] io [4];
    logic [15:0] rd16;

    assign ch_hit[n] = req.addr[AW-1:4] == ADR[AW-1:4];
    assign fld = req.addr[3:0];
    assign wr = req.wr & ch_hit[n];
    assign wd16 = req.wdata[15:0];
    assign be2 = req.be[1:0];
    assign io_wr_h = wr && fld == FLD_IOH && be2[0];
    assign io_wr_l = wr && fld == FLD_IOL && be2[0] && CD;
    assign stat_wr = wr && fld == FLD_STAT && be2[0];
    assign cnt_load = ce_i && wr && fld == FLD_CNT;

    // Each channel chooses its own clock and runs on its own start bit
    assign cks = cfg_r.ctrl[CKS_LSB +: CKS_W];
    assign run = start_r[START_BIT[n]];
    assign tick = ce_i && run && !cks[2] && div_tick[cks[1:0]];
    assign pwm = cfg_r.mode[MD_LSB +: MD_W] == MD_PWM1;

    assign io[0] = cfg_r.io_h[3:0];
    assign io[1] = cfg_r.io_h[7:4];
    assign io[2] = cfg_r.io_l[3:0];
    assign io[3] = cfg_r.io_l[7:4];

    tcp_counter #(
      .HAS_CD(CD)
    ) u_cnt (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .tick_i(tick),
      .cfg_i(cfg_r),
      .load_i(cnt_load),
      .load_val_i(tcp_merge(cnt, wd16, be2)),
      .cnt_o(cnt),
      .match_o(match),
      .ovf_o(ovf)
    );

    // Register writes with byte enables; absent compare C/D stay at reset
    always_comb begin
      cfg_nxt = cfg_r;
      case (fld)
        FLD_CTRL: cfg_nxt.ctrl = 8'(tcp_merge({8'h00, cfg_r.ctrl}, wd16, be2));
        FLD_MODE: cfg_nxt.mode = 8'(tcp_merge({8'h00, cfg_r.mode}, wd16, be2));
        FLD_IOH: cfg_nxt.io_h = 8'(tcp_merge({8'h00, cfg_r.io_h}, wd16, be2));
        FLD_IOL: cfg_nxt.io_l = CD ? cfg_r.io_l : RST_REG8;
        FLD_CMP_A: cfg_nxt.cmp_a = tcp_merge(cfg_r.cmp_a, wd16, be2);
        FLD_CMP_B: cfg_nxt.cmp_b = tcp_merge(cfg_r.cmp_b, wd16, be2);
        FLD_CMP_C: cfg_nxt.cmp_c = CD ? tcp_merge(cfg_r.cmp_c, wd16, be2) : RST_CMP;
        FLD_CMP_D: cfg_nxt.cmp_d = CD ? tcp_merge(cfg_r.cmp_d, wd16, be2) : RST_CMP;
        default: cfg_nxt = cfg_r;
      endcase
      if (fld == FLD_IOL && CD) begin
        cfg_nxt.io_l = 8'(tcp_merge({8'h00, cfg_r.io_l}, wd16, be2));
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        cfg_r <= CFG_RST;
      end else if (ce_i && wr) begin
        cfg_r <= cfg_nxt;
      end
    end

    // Sticky match and overflow flags; a new event wins over a clearing write
    always_comb begin
      stat_nxt = stat_r;
      if (stat_wr) begin
        stat_nxt = stat_r & req.wdata[7:0];
      end
      stat_nxt[3:0] = stat_nxt[3:0] | match;
      stat_nxt[STAT_OVF_BIT] = stat_nxt[STAT_OVF_BIT] | ovf;
      stat_nxt[7:5] = 3'h0;
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        stat_r <= 8'h00;
      end else if (ce_i) begin
        stat_r <= stat_nxt;
      end
    end

    // Pin waveforms: per-pin compare action, or paired PWM in mode 1
    always_comb begin
      pin_nxt = pin_r;
      oe_nxt = oe_r;
      if (pwm) begin
        for (int p = 0; p < 2; p++) begin
          oe_nxt[2*p] = io[2*p] != 4'h0;
          oe_nxt[2*p+1] = 1'b0;
          if (io[2*p] != 4'h0) begin
            // Duty match wins a tie, so duty equal to period holds the pin high
            if (match[2*p+1]) begin
              pin_nxt[2*p] = 1'b1;
            end else if (match[2*p]) begin
              pin_nxt[2*p] = 1'b0;
            end
          end
        end
      end else begin
        for (int k = 0; k < 4; k++) begin
          oe_nxt[k] = !io[k][IO_CAP_BIT] && io[k][1:0] != 2'h0;
          if (match[k] && !io[k][IO_CAP_BIT]) begin
            case (io[k][1:0])
              IO_LOW: pin_nxt[k] = 1'b0;
              IO_HIGH: pin_nxt[k] = 1'b1;
              IO_TOGGLE: pin_nxt[k] = ~pin_r[k];
              default: pin_nxt[k] = pin_r[k];
            endcase
          end
        end
      end
      // A pin control write sets each pin to its initial level
      if (io_wr_h) begin
        pin_nxt[0] = cfg_nxt.io_h[IO_INIT_BIT];
        pin_nxt[1] = cfg_nxt.io_h[4+IO_INIT_BIT];
      end
      if (io_wr_l) begin
        pin_nxt[2] = cfg_nxt.io_l[IO_INIT_BIT];
        pin_nxt[3] = cfg_nxt.io_l[4+IO_INIT_BIT];
      end
      if (!CD) begin
        pin_nxt[3:2] = 2'b00;
        oe_nxt[3:2] = 2'b00;
      end
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        pin_r <= 4'h0;
        oe_r <= 4'h0;
      end else if (ce_i) begin
        pin_r <= pin_nxt;
        oe_r <= oe_nxt;
      end
    end

    // Pins of channel n sit at 4n (A), 4n+1 (B), 4n+2 (C), 4n+3 (D)
    assign pin_o[4*n +: 4] = pin_r;
    assign pin_oe_o[4*n +: 4] = oe_r;

    // Readback of this channel
    always_comb begin
      case (fld)
        FLD_CTRL: rd16 = {8'h00, cfg_r.ctrl};
        FLD_MODE: rd16 = {8'h00, cfg_r.mode};
        FLD_IOH: rd16 = {8'h00, cfg_r.io_h};
        FLD_IOL: rd16 = {8'h00, cfg_r.io_l};
        FLD_STAT: rd16 = {4'h0, pin_r, stat_r};
        FLD_CNT: rd16 = cnt;
        FLD_CMP_A: rd16 = cfg_r.cmp_a;
        FLD_CMP_B: rd16 = cfg_r.cmp_b;
        FLD_CMP_C: rd16 = cfg_r.cmp_c;
        FLD_CMP_D: rd16 = cfg_r.cmp_d;
        default: rd16 = 16'h0000;
      endcase
    end

    assign ch_rdata[n] = ch_hit[n] ? {16'h0000, rd16} : '0;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata = '0;
    if (start_hit) begin
      rdata = {24'h000000, start_r};
    end
    for (int n = 0; n < NCH; n++) begin
      rdata = rdata | ch_rdata[n];
    end
  end
endmodule
`default_nettype wire

// ===== sim/tcp_load_model.sv
// Load model: pulled-down loads on the timer pins, measuring level widths
`default_nettype none
module tcp_load_model
  import tcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic [4*NCH-1:0] pin_i,
  input wire logic [4*NCH-1:0] pin_oe_i,
  output logic [15:0] hi_w_o [5],
  output logic [15:0] lo_w_o [5]
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin reads low through the pull-down
  wire [4*NCH-1:0] lvl = pin_i & pin_oe_i;
  wire [4:0] w = {lvl[14], lvl[12], lvl[8], lvl[4], lvl[0]};
  logic [15:0] run_r [5];
  logic [4:0] last_r;
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) begin
      last_r[k] <= w[k];
      if (w[k] == last_r[k]) begin
        run_r[k] <= run_r[k] + 16'h1;
      end else begin
        run_r[k] <= 16'h1;
        if (last_r[k]) begin
          hi_w_o[k] <= run_r[k];
        end else begin
          lo_w_o[k] <= run_r[k];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tcp_checker.sv
// Checker: bus answer timing, reset state and pin waveforms of the timer
`default_nettype none
module tcp_checker
  import tcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [DW-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [4*NCH-1:0] pin_o,
  input wire logic [4*NCH-1:0] pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Shadow of written registers; the bench always writes both low lanes
  logic [15:0] sh_r [256];
  logic [16:0] gap_r;
  logic [16:0] run_r [2];
  logic [1:0] last_r;
  logic [7:0] ra_r;
  wire take = ce_i && avs_waitrequest_o && (avs_read_i || avs_write_i);
  wire [1:0] pv = {pin_o[4], pin_o[0]};
  wire halted = (sh_r[8'hb0][7:0] & START_MASK) == 8'h00;
  wire pwm1 = sh_r[8'h71][3:0] == MD_PWM1 && sh_r[8'h70][7:0] == 8'h20
    && sh_r[8'h72][3:0] == 4'h2;
  always_ff @(posedge clk_i) begin
    ra_r <= avs_address_i;
    if (sys_rst_i) begin
      for (int i = 0; i < 256; i++) begin
        sh_r[i] <= 16'hffff;
      end
      sh_r[8'hb0] <= 16'h0000;
      gap_r <= '0;
    end else if (take && avs_write_i) begin
      sh_r[avs_address_i] <= avs_writedata_i[15:0];
      gap_r <= '0;
    end else if (gap_r != 17'h1ffff) begin
      gap_r <= gap_r + 17'h1;
    end
  end
  // Cycles each watched pin has held its present level
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 2; k++) begin
      last_r[k] <= pv[k];
      run_r[k] <= (sys_rst_i || pv[k] != last_r[k]) ? 17'h1 : run_r[k] + 17'h1;
    end
  end
  AST_RST_STATE: assert property (disable iff (1'b0) sys_rst_i |=>
    pin_o == '0 && pin_oe_o == '0 && avs_waitrequest_o) else $error("reset state wrong");
  AST_ANSWER: assert property (take |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");
  AST_RD_CMP: assert property (take && avs_read_i && avs_address_i[3:0] == 4'h8
    && avs_address_i[7:4] inside {[4'h6:4'ha]} |=> avs_readdata_o[15:0] == sh_r[ra_r])
    else $error("compare read back wrong");
  AST_HALT: assert property (halted && !avs_write_i |=> $stable(pin_o))
    else $error("pins moved while halted");
  AST_TOGGLE: assert property (pv[0] != last_r[0] && gap_r > run_r[0] + 17'd4
    && sh_r[8'h60][7:0] == 8'h20 && sh_r[8'h62][7:0] == 8'h03 && sh_r[8'h61][3:0] != MD_PWM1
    |-> run_r[0] == sh_r[8'h68] + 17'd1) else $error("toggle half period wrong");
  AST_PWM_HIGH: assert property (!pv[1] && last_r[1] && gap_r > run_r[1] + 17'd4
    && pwm1 && sh_r[8'h79] < sh_r[8'h78] |-> run_r[1] == sh_r[8'h78] - sh_r[8'h79])
    else $error("pwm high width wrong");
  AST_PWM_LOW: assert property (pv[1] && !last_r[1] && gap_r > run_r[1] + 17'd4
    && pwm1 && sh_r[8'h79] < sh_r[8'h78] |-> run_r[1] == sh_r[8'h79] + 17'd1)
    else $error("pwm low width wrong");
  AST_OE: assert property (pwm1 && gap_r > 17'd2 |-> pin_oe_o[4])
    else $error("pwm pin not driven");
  cover property (pv[0] != last_r[0]);
  cover property (pv[1] && !last_r[1] && pwm1);
  cover property (take && avs_read_i && avs_address_i == 8'h5f);
endmodule
bind tcp_timer tcp_checker i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o));
`default_nettype wire

// ===== sim/tcp_timer_tb_top.sv
// Testbench: register access, toggle output, four-phase PWM and counter load
`default_nettype none
module tcp_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [19:0] pin_o;
  logic [19:0] pin_oe_o;
  logic [15:0] hi_w [5];
  logic [15:0] lo_w [5];
  int n_fail = 0;
  int check_count = 0;

  always #2.5 clk_i = ~clk_i;

  tcp_timer i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  tcp_load_model i_load (.clk_i(clk_i), .pin_i(pin_o), .pin_oe_i(pin_oe_o),
    .hi_w_o(hi_w), .lo_w_o(lo_w));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic rd, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int i;
    i = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_byteenable_i <= 4'h3;
    avs_read_i <= rd;
    avs_write_i <= !rd;
    do begin
      @(posedge clk_i);
      i++;
    end while (avs_waitrequest_o !== 1'b0 && i < 40);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
    if (i >= 40) begin
      n_fail++;
      $display("Error t=%0t bus wait at %h", $time, a);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 16'h0000, q);
    chk(q, exp);
  endtask

  task automatic test_reset();
    chk({12'h0, pin_o}, 32'h0);
    rd_chk(8'h68, 32'h0000ffff);
    rd_chk(8'h60, 32'h0);
    rd_chk(8'hb0, 32'h0);
    wr(8'h7a, 16'h1234);
    rd_chk(8'h7a, 32'h0000ffff);
    rd_chk(8'h5f, 32'h0);
    $display("test_reset done");
  endtask

  task automatic test_toggle();
    logic [15:0] n [2] = '{16'h0003, 16'h0001};
    wr(8'h60, 16'h0020);
    wr(8'h62, 16'h0003);
    wr(8'h61, 16'h00c0);
    repeat (20) @(posedge clk_i);
    chk({31'h0, pin_o[0]}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(8'hb0, 16'h0000);
      wr(8'h68, n[k]);
      wr(8'h66, 16'h0000);
      wr(8'hb0, 16'h0001);
      repeat (8 * n[k] + 20) @(posedge clk_i);
      chk({16'h0, hi_w[0]}, {16'h0, n[k] + 16'h1});
      chk({16'h0, lo_w[0]}, {16'h0, n[k] + 16'h1});
    end
    $display("test_toggle done");
  endtask

  task automatic test_pwm();
    logic [15:0] a [3] = '{16'd9, 16'd7, 16'd11};
    logic [15:0] b [3] = '{16'd3, 16'd5, 16'd2};
    logic [7:0] base;
    for (int c = 0; c < 3; c++) begin
      base = 8'h70 + 8'h10 * c[7:0];
      wr(base, 16'h0020);
      wr(base + 8'h8, a[c]);
      wr(base + 8'h9, b[c]);
      wr(base + 8'h2, 16'h0002);
      wr(base + 8'h1, 16'h00c2);
      wr(base + 8'h6, 16'h0000);
    end
    wr(8'h9a, 16'd11);
    wr(8'h9b, 16'd8);
    wr(8'h93, 16'h0021);
    wr(8'hb0, 16'h0046);
    repeat (80) @(posedge clk_i);
    for (int c = 0; c < 3; c++) begin
      chk({16'h0, hi_w[c + 1]}, {16'h0, a[c] - b[c]});
      chk({16'h0, lo_w[c + 1]}, {16'h0, b[c] + 16'h1});
    end
    chk({16'h0, hi_w[4]}, 32'd3);
    chk({16'h0, lo_w[4]}, 32'd9);
    $display("test_pwm done");
  endtask

  task automatic test_duty_ends();
    logic [15:0] bv [2] = '{16'd9, 16'd10};
    for (int k = 0; k < 2; k++) begin
      wr(8'h79, bv[k]);
      repeat (25) @(posedge clk_i);
      repeat (12) begin
        @(posedge clk_i);
        chk({31'h0, pin_o[4]}, {31'h0, k == 0});
      end
    end
    $display("test_duty_ends done");
  endtask

  task automatic test_load();
    wr(8'hb0, 16'h0000);
    wr(8'h66, 16'h1234);
    rd_chk(8'h66, 32'h00001234);
    repeat (10) @(posedge clk_i);
    rd_chk(8'h66, 32'h00001234);
    rd_chk(8'hb0, 32'h0);
    // Clock enable low freezes the count: ticks only on the three enabled edges
    wr(8'h60, 16'h0000);
    wr(8'hb0, 16'h0001);
    ce_i <= 1'b0;
    repeat (50) @(posedge clk_i);
    ce_i <= 1'b1;
    wr(8'hb0, 16'h0000);
    rd_chk(8'h66, 32'h00001237);
    $display("test_load done");
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0; // Block leaves reset out of standby
    @(posedge clk_i);
    test_reset();
    test_toggle();
    test_pwm();
    test_duty_ends();
    test_load();
    end_of_test();
  end

  // Whole run needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
